// ---- brt_defs.svh ----
// constants for the burst ramp and trigger control block
`ifndef BRT_DEFS_SVH
`define BRT_DEFS_SVH
`define BRT_SYM_W 16
`define BRT_OFS_W 8
`define BRT_ATT_W 8
`define BRT_LAT_W 8
`define BRT_PROC_LAT 8'h10
`define BRT_ALIGN_RST 1'b1
`endif

// ---- brt_pkg.sv ----
// types shared by the burst ramp and trigger control block
package brt_pkg;
	typedef enum logic [2:0] {
		BRT_MODE_FREE = 3'h0,
		BRT_MODE_RESTART = 3'h1,
		BRT_MODE_GATED_CONT = 3'h2,
		BRT_MODE_GATED_RESTART = 3'h3,
		BRT_MODE_ONE_SHOT = 3'h4
	} brt_mode_t;
	typedef enum logic [2:0] {
		BRT_ST_STOP = 3'b001,
		BRT_ST_LAT = 3'b010,
		BRT_ST_RUN = 3'b100
	} brt_state_t;
endpackage : brt_pkg

// ---- brt_trig_edge.sv ----
// polarity-selectable edge detector for the external trigger input
module brt_trig_edge (
	input wire logic clk_in,
	input wire logic nrst_in,
	input wire logic trig_in,
	input wire logic falling_in,
	output logic edge_out
);
	logic prev_r;
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			prev_r <= 1'b0;
		end else begin
			prev_r <= trig_in;
		end
	end
	always_comb begin
		if (falling_in) begin
			edge_out = prev_r & ~trig_in;
		end else begin
			edge_out = ~prev_r & trig_in;
		end
	end
endmodule : brt_trig_edge

// ---- brt_level_split.sv ----
// splits the configured attenuation between rf stages and baseband
`include "brt_defs.svh"
module brt_level_split (
	input wire logic [`BRT_ATT_W-1:0] att_in,
	input wire logic [`BRT_ATT_W-1:0] rf_step_in,
	input wire logic active_in,
	input wire logic bb_only_in,
	output logic [`BRT_ATT_W-1:0] rf_att_out,
	output logic [`BRT_ATT_W-1:0] bb_att_out
);
	logic [`BRT_ATT_W-1:0] rf_part;
	always_comb begin
		rf_part = '0;
		if (rf_step_in != '0) begin
			rf_part = att_in - (att_in % rf_step_in);
		end
		if (!active_in) begin
			rf_att_out = '0;
			bb_att_out = '0;
		end else if (bb_only_in) begin
			rf_att_out = '0;
			bb_att_out = att_in;
		end else begin
			rf_att_out = rf_part;
			bb_att_out = att_in - rf_part;
		end
	end
endmodule : brt_level_split

// ---- brt_ctrl.sv ----
// trigger sequencer and burst envelope control
// Overview of operation
// RULE1 - rising envelope edge shifted by signed symbol offset, positive delays it
// RULE2 - falling envelope edge shifted by signed symbol offset, positive delays it
// RULE3 - level reduce high applies configured attenuation, low applies none
// RULE4 - baseband-only off: rf stages take the bulk, baseband the rest
// RULE5 - baseband-only on: whole attenuation done in baseband
// RULE6 - free-running mode generates continuously without triggers
// RULE7 - restart mode runs from outset, each trigger restarts from start
// RULE8 - gated-continuous waits for trigger, halt stops, next trigger restarts
// RULE9 - gated-restart waits, every trigger restarts, halt stops until trigger
// RULE10 - one-shot emits sequence once per trigger, later trigger restarts
// RULE11 - programmable one-shot length in symbols
// RULE12 - status shows running while generating, stopped while waiting
// RULE13 - halt accepted only while running in gated modes
// RULE14 - manual trigger only with internal source and not free-running
// RULE15 - external source triggers on configurable active edge
// RULE16 - alignment option only for external source, defaults on
// RULE17 - alignment on: calculate from trigger, blank output during latency
// RULE18 - alignment off: output starts at sample 0 after latency
// RULE19 - one-shot returns to stopped after programmed length
`include "brt_defs.svh"
module brt_ctrl
	import brt_pkg::*;
(
	input wire logic clk_in,
	input wire logic nrst_in,
	input wire logic enable_in,
	input brt_pkg::brt_mode_t mode_in,
	input wire logic ext_src_in,
	input wire logic ext_falling_in,
	input wire logic ext_trig_in,
	input wire logic manual_trig_in,
	input wire logic halt_in,
	input wire logic align_set_in,
	input wire logic align_val_in,
	input wire logic [`BRT_SYM_W-1:0] seq_len_in,
	input wire logic burst_in,
	input wire logic signed [`BRT_OFS_W-1:0] rise_ofs_in,
	input wire logic signed [`BRT_OFS_W-1:0] fall_ofs_in,
	input wire logic lev_att_in,
	input wire logic [`BRT_ATT_W-1:0] att_in,
	input wire logic [`BRT_ATT_W-1:0] rf_step_in,
	input wire logic bb_only_in,
	output logic running_out,
	output logic sample_valid_out,
	output logic [`BRT_SYM_W-1:0] sample_idx_out,
	output logic calc_restart_out,
	output logic envelope_out,
	output logic [`BRT_ATT_W-1:0] rf_att_out,
	output logic [`BRT_ATT_W-1:0] bb_att_out,
	output logic trigger_aligned_output_out
);
	import brt_pkg::*;

	localparam int HW = 256;

	brt_state_t state_r;
	brt_state_t state_nxt;
	brt_state_t lat_done;
	logic align_r;
	logic ext_edge;
	logic trig_ev;
	logic halt_ok;
	logic gated;
	logic [`BRT_LAT_W-1:0] lat_r;
	logic [`BRT_SYM_W-1:0] calc_r;
	logic [`BRT_SYM_W-1:0] out_cnt_r;
	logic [`BRT_SYM_W-1:0] sym_idx;
	logic out_en;
	logic last_sym;
	logic restart;
	logic [HW-1:0] burst_hist_r;
	logic rise_seen;
	logic fall_seen;
	logic rise_prev_r;
	logic fall_prev_r;
	logic env_r;
	logic [`BRT_ATT_W-1:0] rf_att;
	logic [`BRT_ATT_W-1:0] bb_att;

	function automatic logic hist_tap(input logic [HW-1:0] h, input logic signed [`BRT_OFS_W-1:0] o);
		// the window is centred: tap HW/2 is the zero-offset burst gate, burst_in delayed 129 cycles
		logic [8:0] idx;
		idx = 9'(9'sd128 + 9'(signed'(o)));
		hist_tap = h[idx[7:0]];
	endfunction : hist_tap

	brt_trig_edge u_edge (
		.clk_in(clk_in),
		.nrst_in(nrst_in),
		.trig_in(ext_trig_in),
		.falling_in(ext_falling_in),
		.edge_out(ext_edge)
	);

	brt_level_split u_split (
		.att_in(att_in),
		.rf_step_in(rf_step_in),
		.active_in(lev_att_in), // RULE3
		.bb_only_in(bb_only_in),
		.rf_att_out(rf_att),
		.bb_att_out(bb_att)
	);

	assign gated = (mode_in == BRT_MODE_GATED_CONT) || (mode_in == BRT_MODE_GATED_RESTART);

	always_comb begin
		trig_ev = 1'b0;
		if (enable_in && mode_in != BRT_MODE_FREE) begin
			if (ext_src_in) begin
				trig_ev = ext_edge; // RULE15
			end else begin
				trig_ev = manual_trig_in; // RULE14
			end
		end
	end

	// halt only acts while not stopped (latency or run phase) in a gated mode
	assign halt_ok = halt_in && gated && (state_r != BRT_ST_STOP); // RULE13

	assign last_sym = (mode_in == BRT_MODE_ONE_SHOT) && (state_r == BRT_ST_RUN)
		&& (out_cnt_r + 16'h0001 >= seq_len_in);

	always_comb begin
		// latency drain is the default move; mode decisions below override it
		state_nxt = lat_done;
		restart = 1'b0;
		if (!enable_in) begin
			state_nxt = BRT_ST_STOP;
		end else begin
			case (mode_in)
				BRT_MODE_FREE: begin
					if (state_r == BRT_ST_STOP) begin
						state_nxt = BRT_ST_LAT; // RULE6
						restart = 1'b1;
					end
				end
				BRT_MODE_RESTART: begin
					if (state_r == BRT_ST_STOP || trig_ev) begin
						state_nxt = BRT_ST_LAT; // RULE7
						restart = 1'b1;
					end
				end
				BRT_MODE_GATED_CONT: begin
					if (halt_ok) begin
						state_nxt = BRT_ST_STOP; // RULE8
					end else if (state_r == BRT_ST_STOP && trig_ev) begin
						state_nxt = BRT_ST_LAT; // RULE8
						restart = 1'b1;
					end
				end
				BRT_MODE_GATED_RESTART: begin
					if (halt_ok) begin
						state_nxt = BRT_ST_STOP; // RULE9
					end else if (trig_ev) begin
						state_nxt = BRT_ST_LAT; // RULE9
						restart = 1'b1;
					end
				end
				BRT_MODE_ONE_SHOT: begin
					if (trig_ev) begin
						state_nxt = BRT_ST_LAT; // RULE10
						restart = 1'b1;
					end else if (last_sym || (state_r != BRT_ST_STOP && seq_len_in == '0)) begin
						state_nxt = BRT_ST_STOP; // RULE19
					end
				end
				default: begin
					state_nxt = BRT_ST_STOP;
				end
			endcase
		end
	end

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			state_r <= BRT_ST_STOP;
		end else begin
			state_r <= state_nxt;
		end
	end

	// alignment is only meaningful with external triggering
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			align_r <= `BRT_ALIGN_RST; // RULE16
		end else if (align_set_in && ext_src_in) begin
			align_r <= align_val_in; // RULE16
		end
	end

	// latency counter; calc index counts from the trigger regardless of alignment
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			lat_r <= '0;
			calc_r <= '0;
		end else if (restart) begin
			lat_r <= `BRT_PROC_LAT;
			calc_r <= '0;
		end else begin
			if (lat_r != '0) begin
				lat_r <= lat_r - 8'h01;
			end
			if (state_r != BRT_ST_STOP) begin
				calc_r <= calc_r + 16'h0001;
			end
		end
	end

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			out_cnt_r <= '0;
		end else if (restart) begin
			out_cnt_r <= '0;
		end else if (state_r == BRT_ST_RUN) begin
			out_cnt_r <= out_cnt_r + 16'h0001; // RULE11
		end
	end

	// aligned: latency samples are cut off; unaligned: sequence starts at 0
	always_comb begin
		if (ext_src_in && align_r) begin
			sym_idx = calc_r; // RULE17
		end else begin
			sym_idx = out_cnt_r; // RULE18
		end
	end

	assign out_en = (state_r == BRT_ST_RUN) && !(ext_src_in && align_r && seq_len_in != '0
		&& mode_in == BRT_MODE_ONE_SHOT && calc_r >= seq_len_in);

	// registered running, sample, restart and alignment status outputs
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			running_out <= 1'b0;
			sample_valid_out <= 1'b0;
			sample_idx_out <= '0;
			calc_restart_out <= 1'b0;
			trigger_aligned_output_out <= `BRT_ALIGN_RST;
		end else begin
			running_out <= (state_nxt != BRT_ST_STOP); // RULE12
			// a restart drops the stale sample of the aborted run
			sample_valid_out <= out_en && !restart; // RULE17
			sample_idx_out <= sym_idx;
			calc_restart_out <= restart;
			trigger_aligned_output_out <= align_r && ext_src_in;
		end
	end

	// latency to run transition kept apart from the mode decisions above
	always_comb begin
		lat_done = state_r;
		if (state_r == BRT_ST_LAT && lat_r == 8'h01) begin
			lat_done = BRT_ST_RUN;
		end
	end

	// burst gate history for symmetric early/late edge shifts
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			burst_hist_r <= '0;
		end else begin
			burst_hist_r <= {burst_hist_r[HW-2:0], burst_in};
		end
	end

	// rise: positive offset waits longer before opening; fall: positive holds longer
	assign rise_seen = hist_tap(burst_hist_r, rise_ofs_in); // RULE1
	assign fall_seen = hist_tap(burst_hist_r, fall_ofs_in); // RULE2

	// edge of each tap, so opening and closing stay independent of the tap gap
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			rise_prev_r <= 1'b0;
			fall_prev_r <= 1'b0;
		end else begin
			rise_prev_r <= rise_seen;
			fall_prev_r <= fall_seen;
		end
	end

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			env_r <= 1'b0;
		end else if (rise_seen && !rise_prev_r) begin
			env_r <= 1'b1; // RULE1
		end else if (!fall_seen && fall_prev_r) begin
			env_r <= 1'b0; // RULE2
		end
	end

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			envelope_out <= 1'b0;
			rf_att_out <= '0;
			bb_att_out <= '0;
		end else begin
			envelope_out <= env_r;
			rf_att_out <= rf_att; // RULE4
			bb_att_out <= bb_att; // RULE5
		end
	end
endmodule : brt_ctrl

// ---- brt_ext_trig_src.sv ----
// external trigger source model driving the trigger pin of the control block
module brt_ext_trig_src (
	input wire logic clk_in,
	input wire logic falling_in,
	output logic trig_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic act_r = 1'b0;
	// rests at the inactive level so only fire() gives an active edge
	assign trig_out = act_r ^ falling_in;
	task automatic fire;
		@(posedge clk_in);
		#2 act_r = 1'b1;
		repeat (3) @(posedge clk_in);
		#2 act_r = 1'b0;
	endtask : fire
endmodule : brt_ext_trig_src

// ---- brt_ctrl_chk.sv ----
// port checker for the burst ramp and trigger control block
`include "brt_defs.svh"
module brt_ctrl_chk (
	input wire logic clk_in,
	input wire logic nrst_in,
	input wire logic enable_in,
	input brt_pkg::brt_mode_t mode_in,
	input wire logic ext_src_in,
	input wire logic ext_falling_in,
	input wire logic ext_trig_in,
	input wire logic manual_trig_in,
	input wire logic halt_in,
	input wire logic lev_att_in,
	input wire logic [`BRT_ATT_W-1:0] att_in,
	input wire logic bb_only_in,
	input wire logic running_out,
	input wire logic sample_valid_out,
	input wire logic [`BRT_SYM_W-1:0] sample_idx_out,
	input wire logic calc_restart_out,
	input wire logic [`BRT_ATT_W-1:0] rf_att_out,
	input wire logic [`BRT_ATT_W-1:0] bb_att_out,
	input wire logic trigger_aligned_output_out
);
	import brt_pkg::*;
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!nrst_in);
	a_manual_starts: assert property (manual_trig_in && enable_in && !ext_src_in && !running_out
		&& mode_in == BRT_MODE_GATED_CONT |=> running_out && calc_restart_out)
		else $error("manual trigger did not start generation");
	a_free_refuse: assert property (manual_trig_in && !ext_src_in
		&& mode_in == BRT_MODE_FREE |=> !calc_restart_out)
		else $error("manual trigger taken in free mode");
	a_halt_stops: assert property (halt_in && running_out && !manual_trig_in && !ext_src_in
		&& (mode_in == BRT_MODE_GATED_CONT || mode_in == BRT_MODE_GATED_RESTART) |=> !running_out)
		else $error("halt did not stop generation");
	a_att_off: assert property (!lev_att_in |=> rf_att_out == '0 && bb_att_out == '0)
		else $error("attenuation applied with level reduce low");
	a_bb_only: assert property (lev_att_in && bb_only_in
		|=> rf_att_out == '0 && bb_att_out == $past(att_in))
		else $error("baseband only split wrong");
	a_lat_blank: assert property (calc_restart_out |-> !sample_valid_out [*8])
		else $error("samples shown during processing latency");
	a_ext_edge: assert property (ext_src_in && enable_in && !running_out && mode_in == BRT_MODE_ONE_SHOT
		&& (ext_falling_in ? $fell(ext_trig_in) : $rose(ext_trig_in)) |-> ##[1:3] running_out)
		else $error("external edge did not start generation");
	a_first_idx: assert property ($rose(sample_valid_out) && !trigger_aligned_output_out
		|-> sample_idx_out == '0)
		else $error("unaligned output did not start at sample zero");
	c_restart: cover property (calc_restart_out);
	c_stop: cover property ($fell(running_out));
	c_rf_part: cover property (lev_att_in && !bb_only_in && rf_att_out != '0);
endmodule : brt_ctrl_chk
bind brt_ctrl brt_ctrl_chk i_brt_ctrl_chk (.clk_in, .nrst_in, .enable_in, .mode_in, .ext_src_in,
	.ext_falling_in, .ext_trig_in, .manual_trig_in, .halt_in, .lev_att_in, .att_in, .bb_only_in,
	.running_out, .sample_valid_out, .sample_idx_out, .calc_restart_out, .rf_att_out, .bb_att_out,
	.trigger_aligned_output_out);

// ---- test_burst_ramp_trigger_control.sv ----
// self-checking bench for the burst ramp and trigger control block
`include "brt_defs.svh"
module test_burst_ramp_trigger_control;
	timeunit 1ns;
	timeprecision 1ns;
	import brt_pkg::*;
	logic clk_in = 0, nrst_in = 0, enable_in = 1, ext_src_in = 0, ext_falling_in = 0;
	logic manual_trig_in = 0, halt_in = 0, align_set_in = 0, align_val_in = 0;
	logic burst_in = 0, lev_att_in = 0, bb_only_in = 0, ext_trig_in;
	brt_mode_t mode_in = BRT_MODE_FREE;
	logic [`BRT_SYM_W-1:0] seq_len_in = '0, sample_idx_out, first_idx;
	logic signed [`BRT_OFS_W-1:0] rise_ofs_in = '0, fall_ofs_in = '0;
	logic [`BRT_ATT_W-1:0] att_in = '0, rf_step_in = '0, rf_att_out, bb_att_out;
	logic running_out, sample_valid_out, calc_restart_out, envelope_out, trigger_aligned_output_out;
	int fail_count = 0, samples_checked = 0, n_valid, n_env, e_rf, e_bb;
	brt_ctrl i_brt_ctrl (.clk_in, .nrst_in, .enable_in, .mode_in, .ext_src_in, .ext_falling_in,
		.ext_trig_in, .manual_trig_in, .halt_in, .align_set_in, .align_val_in, .seq_len_in,
		.burst_in, .rise_ofs_in, .fall_ofs_in, .lev_att_in, .att_in, .rf_step_in, .bb_only_in,
		.running_out, .sample_valid_out, .sample_idx_out, .calc_restart_out, .envelope_out,
		.rf_att_out, .bb_att_out, .trigger_aligned_output_out);
	brt_ext_trig_src i_brt_ext_trig_src (.clk_in, .falling_in(ext_falling_in), .trig_out(ext_trig_in));
	always #25 clk_in = ~clk_in;
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_in);
		#2;
	endtask : cyc
	task automatic rst;
		nrst_in = 0;
		cyc(4);
		nrst_in = 1;
		cyc(1);
	endtask : rst
	task automatic pulse(ref logic s);
		s = 1;
		cyc(1);
		s = 0;
	endtask : pulse
	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got);
		end
	endtask : chk
	// samples trail the running flag, so count on until both are low; bounded
	task automatic run_cnt;
		n_valid = 0;
		first_idx = 16'hffff;
		for (int i = 0; i < 300 && (running_out === 1'b1 || sample_valid_out === 1'b1); i++) begin
			if (sample_valid_out === 1'b1) begin
				if (n_valid == 0) first_idx = sample_idx_out;
				n_valid++;
			end
			cyc(1);
		end
	endtask : run_cnt
	task automatic end_sim;
		$display("comparisons %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : end_sim
	initial begin
		#500000;
		fail_count++;
		end_sim();
	end
	initial begin
		void'($urandom(32'h8fe76605));
		for (int m = 0; m < 5; m++) begin
			mode_in = brt_mode_t'(m);
			seq_len_in = 16'h0040;
			rst();
			cyc(2);
			chk("running idle", m < 2, running_out);
			pulse(manual_trig_in);
			chk("restart pulse", m != 0, calc_restart_out);
			chk("running trig", 1'b1, running_out);
			cyc(30);
			pulse(halt_in);
			chk("running halt", !(m == 2 || m == 3), running_out);
			pulse(manual_trig_in);
			chk("rearm", 1'b1, running_out);
		end
		mode_in = BRT_MODE_ONE_SHOT;
		seq_len_in = 16'($urandom_range(51, 20));
		rst();
		ext_src_in = 1;
		cyc(1);
		chk("align default", 1'b1, trigger_aligned_output_out);
		ext_src_in = 0;
		pulse(align_set_in);
		ext_src_in = 1;
		cyc(1);
		chk("align refused", 1'b1, trigger_aligned_output_out);
		ext_src_in = 0;
		pulse(manual_trig_in);
		run_cnt();
		chk("one shot count", seq_len_in, n_valid);
		chk("one shot stop", 1'b0, running_out);
		for (int f = 0; f < 2; f++) begin
			ext_src_in = 1;
			ext_falling_in = f[0];
			seq_len_in = 16'h0018;
			rst();
			align_val_in = f[0];
			pulse(align_set_in);
			i_brt_ext_trig_src.fire();
			chk("ext running", 1'b1, running_out);
			run_cnt();
			chk("first idx", f ? `BRT_PROC_LAT : 0, first_idx);
			chk("shown count", f ? 24 - `BRT_PROC_LAT : 24, n_valid);
		end
		ext_src_in = 0;
		ext_falling_in = 0;
		for (int i = 0; i < 8; i++) begin
			att_in = 8'($urandom);
			rf_step_in = 8'($urandom_range(9, 0));
			bb_only_in = i[0];
			lev_att_in = i < 6;
			cyc(2);
			e_rf = (!lev_att_in || bb_only_in || rf_step_in == 0) ? 0 : att_in / rf_step_in * rf_step_in;
			e_bb = lev_att_in ? att_in - e_rf : 0;
			chk("rf att", e_rf, rf_att_out);
			chk("bb att", e_bb, bb_att_out);
		end
		mode_in = BRT_MODE_FREE;
		rst();
		for (int k = 0; k < 2; k++) begin
			rise_ofs_in = k ? -8'sd4 : 8'sd3;
			fall_ofs_in = k ? 8'sd5 : -8'sd2;
			cyc(300);
			n_env = 0;
			for (int j = 0; j < 440; j++) begin
				burst_in = j < 40;
				cyc(1);
				if (envelope_out === 1'b1) n_env++;
			end
			chk("envelope len", 40 - rise_ofs_in + fall_ofs_in, n_env);
		end
		enable_in = 0;
		cyc(2);
		chk("disabled stop", 1'b0, running_out);
		end_sim();
	end
endmodule : test_burst_ramp_trigger_control
